// *** hw/async_serial_tx_rx_core.sv ***
// Full-duplex asynchronous serial port core with APB register access
// Notes on behaviour
// - One data address: read gives receive buffer, write loads transmit buffer.
// - One baud generator from the bus clock feeds transmitter and receiver.
// - Transmit line idles high after reset; invert control flips every level.
// - Enabling the transmitter queues one idle frame, then waits for data.
// - Transmit frame is 10 bits, or 11 in nine-bit mode.
// - Free shifter takes buffered character on bit tick and sets buffer-empty.
// - Nothing waiting after stop bit: set transmit-complete, line stays idle.
// - Disabling transmitter keeps the pin until data, idle, break all finish.
// - A send-break pulse queues one break; still high at load queues another.
// - Break lasts 10 or 11 bit times, 13 or 14 with long break.
// - Transmit enable off then on queues one idle frame.
// - Receive enable starts receiver; receive invert flips input first.
// - Frame: low start, eight or nine data bits LSB first, high stop.
// - After stop, move to buffer and set full; if full, set overrun instead.
// - Sample at 16x; a low after three highs is a falling edge.
// - Start qualified by two of three low samples at RT3, RT5, RT7.
// - Each bit decided by majority at RT8-10; start bit forced low.
// - Any sample disagreeing with its bit level sets noise at transfer.
// - Edge search runs all the time and resyncs bit phase on each edge.
// - Framing error on a non-break preloads three high edge samples.
// - While framing flag is set, completed characters are not transferred.
// - Receive-full clears by status read while set, then data read.
// - Ninth transmit bit copied into shifter together with the data byte.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module async_serial_tx_rx_core
  import serial_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DIV_W  = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   txd,
  output logic                   tx_owned,
  input  wire logic              rxd
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (ADDR_W < 8 || DIV_W < 16 || DIV_W > 32) begin : g_bad_param
    $error("async_serial_tx_rx_core: ADDR_W must be >= 8, DIV_W 16..32");
  end

  // All state of the block
  typedef struct packed {
    logic [DIV_W-1:0] baud_div;
    logic [DIV_W-1:0] div_cnt;
    logic [7:0]       ctrl;
    logic [7:0]       tx_buf;
    logic             tx_buffer_empty;
    logic             tc;
    logic             brk_q;
    logic             idle_q;
    logic [3:0]       tx_sub;
    logic [13:0]      tx_sh;
    logic [3:0]       tx_cnt;
    logic             txd;
    logic             owned;
    rx_st_e           rx_st;
    logic [4:0]       rt;
    logic [2:0]       vote;
    logic [2:0]       hist;
    logic [3:0]       bit_idx;
    logic [8:0]       rx_sh;
    logic             rx_nf;
    logic [8:0]       rx_buf;
    logic             rx_buffer_full;
    logic             ovr;
    logic             nf;
    logic             fe;
    logic [3:0]       arm;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
  } core_s;

  core_s st_r;
  core_s st_nxt;

  // Events exposed for the checks below
  logic tick;
  logic bit_tick;
  logic ld_data;
  logic ld_brk;
  logic rx_done;
  logic rx_stop;
  logic rx_brk;
  logic fall;
  logic acc_done;
  logic stat_rd;
  logic data_rd;

  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic              nine;
    logic              rx_s;
    logic [4:0]        rt_inc;
    logic [2:0]        vote3;
    logic              lvl;
    logic [8:0]        word;
    logic [3:0]        stop_idx;
    logic [7:0]        stat;
    st_nxt   = st_r;
    a        = paddr;
    nine     = st_r.ctrl[CB_NINE];
    rx_s     = rxd ^ st_r.ctrl[CB_RX_INVERT];
    rt_inc   = (st_r.rt == RT_LAST) ? RT_FIRST : st_r.rt + 5'h01;
    vote3    = st_r.vote;
    lvl      = 1'b0;
    word     = nine ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
    stop_idx = nine ? STOP_IDX_9 : STOP_IDX_8;
    stat     = {st_r.tx_buffer_empty, st_r.tc, st_r.rx_buffer_full, 1'b0, st_r.ovr, st_r.nf, st_r.fe,
                st_r.rx_buf[8]};
    ld_data  = 1'b0;
    ld_brk   = 1'b0;
    rx_done  = 1'b0;
    rx_stop  = 1'b0;
    rx_brk   = 1'b0;
    fall     = (st_r.hist == 3'b111) && !rx_s;
    acc_done = psel && penable && st_r.ready;
    stat_rd  = acc_done && !pwrite && (a[7:0] == OFF_STAT);
    data_rd  = acc_done && !pwrite && (a[7:0] == OFF_DATA);

    // Shared 16x tick: bus clock divided by the programmed modulo
    tick = (st_r.baud_div != '0) && (st_r.div_cnt == st_r.baud_div - 1'b1);
    st_nxt.div_cnt = (tick || st_r.baud_div == '0) ? '0 : st_r.div_cnt + 1'b1;
    bit_tick = tick && (st_r.tx_sub == SUB_LAST);
    if (tick) begin
      st_nxt.tx_sub = st_r.tx_sub + 4'h1;
    end

    // Bus slave: one wait state, read data captured in the first access cycle
    st_nxt.ready = psel && penable && !st_r.ready;
    if (psel && penable && !st_r.ready) begin
      st_nxt.err   = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      case (a[7:0])
        OFF_BAUD: st_nxt.rdata[DIV_W-1:0] = st_r.baud_div;
        OFF_CTRL: st_nxt.rdata[7:0] = st_r.ctrl;
        OFF_STAT: st_nxt.rdata[7:0] = stat;
        OFF_DATA: st_nxt.rdata[7:0] = st_r.rx_buf[7:0];
        default:  st_nxt.err = 1'b1;
      endcase
      if (a[ADDR_W-1:2] > (ADDR_W-2)'(OFF_DATA[7:2]) || a[1:0] != 2'b00) begin
        st_nxt.err = 1'b1;
      end
    end

    // Register writes and the flag-clearing sequence take effect at completion
    if (acc_done && pwrite) begin
      case (a[7:0])
        OFF_BAUD: begin
          st_nxt.baud_div = pwdata[DIV_W-1:0];
          st_nxt.div_cnt  = '0;
        end
        OFF_CTRL: begin
          st_nxt.ctrl = pwdata[7:0];
          if (pwdata[CB_TXEN] && !st_r.ctrl[CB_TXEN]) begin
            st_nxt.idle_q = 1'b1;
            st_nxt.tc     = 1'b0;
          end
          if (pwdata[CB_SBK] && !st_r.ctrl[CB_SBK]) begin
            st_nxt.brk_q = 1'b1;
            st_nxt.tc    = 1'b0;
          end
        end
        OFF_DATA: begin
          st_nxt.tx_buf = pwdata[7:0];
          st_nxt.tx_buffer_empty   = 1'b0;
          st_nxt.tc     = 1'b0;
        end
        default: ;
      endcase
    end
    // Status read arms the clear; data read clears what was seen set
    if (stat_rd) begin
      st_nxt.arm = {st_r.rx_buffer_full, st_r.ovr, st_r.nf, st_r.fe};
    end
    if (data_rd) begin
      st_nxt.rx_buffer_full = st_r.rx_buffer_full & ~st_r.arm[3];
      st_nxt.ovr  = st_r.ovr & ~st_r.arm[2];
      st_nxt.nf   = st_r.nf & ~st_r.arm[1];
      st_nxt.fe   = st_r.fe & ~st_r.arm[0];
      st_nxt.arm  = 4'h0;
    end

    // Transmitter: shifter advances one bit per 16 ticks
    if (bit_tick) begin
      if (st_r.tx_cnt > 4'h1) begin
        st_nxt.tx_sh  = {1'b1, st_r.tx_sh[13:1]};
        st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
      end else if (st_r.idle_q) begin
        st_nxt.tx_sh  = '1;
        st_nxt.tx_cnt = nine ? LEN_9 : LEN_8;
        st_nxt.idle_q = 1'b0;
      end else if (st_r.brk_q) begin
        ld_brk        = 1'b1;
        st_nxt.tx_sh  = '0;
        st_nxt.tx_cnt = st_r.ctrl[CB_LBRK] ? (nine ? LEN_9_LONG : LEN_8_LONG)
                                           : (nine ? LEN_9 : LEN_8);
        st_nxt.brk_q  = st_r.ctrl[CB_SBK];
      end else if (!st_r.tx_buffer_empty && st_r.ctrl[CB_TXEN]) begin
        ld_data       = 1'b1;
        // Start low first, stop high last, LSB first on the line
        st_nxt.tx_sh  = nine ? {3'b111, 1'b1, st_r.ctrl[CB_T8], st_r.tx_buf, 1'b0}
                             : {4'hf, 1'b1, st_r.tx_buf, 1'b0};
        st_nxt.tx_cnt = nine ? LEN_9 : LEN_8;
        st_nxt.tx_buffer_empty   = 1'b1;
      end else begin
        if (st_r.tx_cnt == 4'h1) begin
          st_nxt.tc = 1'b1;
        end
        st_nxt.tx_cnt = 4'h0;
      end
    end
    // Pin stays owned while anything is in flight or queued
    st_nxt.owned = st_nxt.ctrl[CB_TXEN] || st_nxt.tx_cnt != 4'h0 ||
                   st_nxt.idle_q || st_nxt.brk_q;
    st_nxt.txd = ((st_nxt.tx_cnt != 4'h0) ? st_nxt.tx_sh[0] : 1'b1)
                 ^ st_nxt.ctrl[CB_TX_INVERT];

    // Receiver: 16x sampling, edge history always kept while enabled
    if (!st_r.ctrl[CB_RXEN]) begin
      st_nxt.rx_st = RX_HUNT;
      st_nxt.hist  = 3'h0;
    end else if (tick) begin
      st_nxt.hist = {st_r.hist[1:0], rx_s};
      case (st_r.rx_st)
        RX_HUNT: begin
          if (fall) begin
            st_nxt.rx_st   = RX_START;
            st_nxt.rt      = RT_FIRST;
            st_nxt.rx_nf   = 1'b0;
            st_nxt.bit_idx = 4'h0;
          end
        end
        RX_START: begin
          st_nxt.rt = rt_inc;
          if (rt_inc == RT_3 || rt_inc == RT_5 || rt_inc == RT_7) begin
            vote3 = {st_r.vote[1:0], rx_s};
          end
          st_nxt.vote = vote3;
          if (rt_inc == RT_7) begin
            if (maj3(vote3)) begin
              st_nxt.rx_st = RX_HUNT;
            end else begin
              st_nxt.rx_st = RX_BITS;
              st_nxt.rx_nf = (vote3 != 3'b000);
            end
          end
        end
        RX_BITS: begin
          // A fresh edge restarts the bit phase at RT1
          st_nxt.rt = fall ? RT_FIRST : rt_inc;
          if (!fall && (rt_inc == RT_8 || rt_inc == RT_9 || rt_inc == RT_10)) begin
            vote3 = {st_r.vote[1:0], rx_s};
          end
          st_nxt.vote = vote3;
          if (!fall && rt_inc == RT_10) begin
            lvl = (st_r.bit_idx == 4'h0) ? 1'b0 : maj3(vote3);
            if (vote3 != {3{lvl}}) begin
              st_nxt.rx_nf = 1'b1;
            end
            if (st_r.bit_idx != 4'h0 && st_r.bit_idx != stop_idx) begin
              st_nxt.rx_sh = {lvl, st_r.rx_sh[8:1]};
            end
            st_nxt.bit_idx = st_r.bit_idx + 4'h1;
            if (st_r.bit_idx == stop_idx) begin
              rx_done      = 1'b1;
              rx_stop      = lvl;
              rx_brk       = !lvl && (word == 9'h000);
              st_nxt.rx_st = RX_HUNT;
              // Skip the three-high wait so a back-to-back start is caught
              st_nxt.hist  = (!lvl && !rx_brk) ? 3'b111 : 3'b000;
              if (st_r.fe) begin
                // Shifter keeps running but nothing lands in the buffer
              end else if (st_r.rx_buffer_full && st_nxt.rx_buffer_full) begin
                st_nxt.ovr = 1'b1;
              end else begin
                st_nxt.rx_buf = word;
                st_nxt.rx_buffer_full   = 1'b1;
                st_nxt.nf     = st_nxt.rx_nf;
                st_nxt.fe     = !lvl;
              end
            end
          end
        end
        default: st_nxt.rx_st = RX_HUNT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.baud_div <= DIV_W'(BAUD_RST);
      st_r.ctrl     <= CTRL_RST;
      st_r.tx_buffer_empty     <= 1'b1;
      st_r.tc       <= 1'b1;
      st_r.txd      <= 1'b1;
      st_r.rx_st    <= RX_HUNT;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign prdata   = st_r.rdata;
  assign pready   = st_r.ready;
  assign pslverr  = st_r.err;
  assign txd      = st_r.txd;
  assign tx_owned = st_r.owned;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_TXD_IDLE: assert property (
    st_r.tx_cnt == 4'h0 |-> st_r.txd == !st_r.ctrl[CB_TX_INVERT])
    else $error("transmit line not at idle level while shifter empty");

  AST_LOAD_DATA: assert property (
    clk_en && ld_data |=> st_r.tx_buffer_empty && st_r.tx_cnt == (st_r.ctrl[CB_NINE] ? LEN_9 : LEN_8))
    else $error("data load did not set buffer-empty or frame length");

  AST_BREAK_LEN: assert property (
    clk_en && ld_brk && st_r.ctrl[CB_LBRK] && !st_r.ctrl[CB_NINE] && !(acc_done && pwrite)
    |=> st_r.tx_cnt == LEN_8_LONG && st_r.tx_sh == 14'h0000)
    else $error("long break length wrong");

  AST_BREAK_LOW: assert property (
    clk_en && ld_brk ##1 (st_r.tx_cnt != 4'h0) [*8] |-> !st_r.txd == !st_r.ctrl[CB_TX_INVERT])
    else $error("break not held at space level");

  AST_OVERRUN: assert property (
    clk_en && rx_done && st_r.rx_buffer_full && !st_r.fe && !data_rd |=> st_r.ovr && $stable(st_r.rx_buf))
    else $error("overrun not flagged or buffer overwritten");

  AST_FE_HOLD: assert property (
    clk_en && rx_done && st_r.fe |=> $stable(st_r.rx_buf))
    else $error("character transferred while framing flag set");

  AST_PRELOAD: assert property (
    clk_en && rx_done && !rx_stop && !rx_brk |=> st_r.hist == 3'b111 && st_r.rx_st == RX_HUNT)
    else $error("edge history not preloaded after framing error");

  AST_FE_SET: assert property (
    clk_en && rx_done && !rx_stop && !st_r.rx_buffer_full && !st_r.fe |=> st_r.fe && st_r.rx_buffer_full)
    else $error("framing flag not set with buffer-full");

  AST_RX_BUFFER_FULL_CLEAR: assert property (
    $fell(st_r.rx_buffer_full) |-> $past(data_rd) && $past(st_r.arm[3]))
    else $error("buffer-full cleared without status then data read");

  // Receive line as the voter sees it, for the start rejection check
  logic rx_s_q;
  assign rx_s_q = rxd ^ st_r.ctrl[CB_RX_INVERT];

  AST_START_REJECT: assert property (
    clk_en && tick && st_r.rx_st == RX_START && st_r.rt == 5'h06 && st_r.ctrl[CB_RXEN]
    && maj3({st_r.vote[1:0], rx_s_q}) |=> st_r.rx_st == RX_HUNT)
    else $error("start accepted with fewer than two low samples");

  COV_DATA_SENT: cover property (clk_en && ld_data ##[1:400] st_r.tc);
  COV_RX_OK: cover property (clk_en && rx_done && rx_stop && !st_r.rx_buffer_full);
  COV_OVERRUN: cover property (clk_en && rx_done && st_r.rx_buffer_full);
  COV_BREAK_RX: cover property (clk_en && rx_done && rx_brk);

endmodule

// *** hw/serial_pkg.sv ***
// Shared constants and types for the asynchronous serial port core
package serial_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BAUD = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;

  // Control register bit positions
  localparam int CB_TXEN  = 0;
  localparam int CB_RXEN  = 1;
  localparam int CB_SBK   = 2;
  localparam int CB_LBRK  = 3;
  localparam int CB_NINE  = 4;
  localparam int CB_TX_INVERT = 5;
  localparam int CB_RX_INVERT = 6;
  localparam int CB_T8    = 7;

  // Status register bit positions
  localparam int SB_R8   = 0;
  localparam int SB_FE   = 1;
  localparam int SB_NF   = 2;
  localparam int SB_OR   = 3;
  localparam int SB_RX_BUFFER_FULL = 5;
  localparam int SB_TC   = 6;
  localparam int SB_TX_BUFFER_EMPTY = 7;

  // Values after reset
  localparam logic [15:0] BAUD_RST = 16'h001b;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // Frame and break lengths in bit times
  localparam logic [3:0] LEN_8      = 4'ha;
  localparam logic [3:0] LEN_9      = 4'hb;
  localparam logic [3:0] LEN_8_LONG = 4'hd;
  localparam logic [3:0] LEN_9_LONG = 4'he;

  // Oversampling positions inside one bit time, RT1 is the edge sample
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_3     = 5'h03;
  localparam logic [4:0] RT_5     = 5'h05;
  localparam logic [4:0] RT_7     = 5'h07;
  localparam logic [4:0] RT_8     = 5'h08;
  localparam logic [4:0] RT_9     = 5'h09;
  localparam logic [4:0] RT_10    = 5'h0a;
  localparam logic [4:0] RT_LAST  = 5'h10;
  localparam logic [3:0] SUB_LAST = 4'hf;

  // Index of the stop bit, counting the start bit as zero
  localparam logic [3:0] STOP_IDX_8 = 4'h9;
  localparam logic [3:0] STOP_IDX_9 = 4'ha;

  // Receiver states, Gray coded along hunt, start, bits
  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b11
  } rx_st_e;

endpackage

// *** verif/serial_peer.sv ***
// Remote serial device model facing the core's transmit and receive pins
`timescale 1ns/100ps
module serial_peer #(
  parameter int BIT_CLKS = 16,
  parameter int CLK_NS   = 20
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_byte = 8'h00;
  logic [7:0] sh;
  int         ev_count = 0;
  int         low_len  = 0;
  time        first_start = 0;
  time        t0;

  initial rxd = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // One frame onto rxd; glt picks a bit whose middle sample is flipped
  task automatic send(input logic [7:0] d, input logic stp, input int glt);
    logic [9:0] fr;
    fr = {stp, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge clk);
        rxd <= (b == glt && c == 8) ? ~fr[b] : fr[b];
      end
    end
    @(posedge clk);
    rxd <= 1'b1; // Line returns to idle high
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Decodes frames at mid-bit; a low stop means a break, so its length is kept
  always begin
    @(negedge txd);
    t0 = $time;
    if (first_start == 0) begin
      first_start = $time;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    if (txd === 1'b1) begin
      got_byte = sh;
    end else begin
      @(posedge txd);
      low_len = int'(($time - t0) / CLK_NS);
    end
    ev_count++;
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the asynchronous serial port core
`timescale 1ns/100ps
module testbench;
  import serial_pkg::*;
  localparam int BIT_CLKS = 16;
  logic        clk      = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txd;
  logic        tx_owned;
  logic        rxd;
  logic [31:0] rd;
  logic        perr;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  time         t_en;

  // Bus clock, 50 MHz
  always #10 clk = ~clk;

  async_serial_tx_rx_core uut (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (1'b1),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .txd      (txd),
    .tx_owned (tx_owned),
    .rxd      (rxd)
  );

  serial_peer #(.BIT_CLKS(BIT_CLKS), .CLK_NS(20)) peer (
    .clk (clk),
    .txd (txd),
    .rxd (rxd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      err_total++;
      $display("unexpected at %0t: wait ran out, got %h expected %h", $time, cnt, 0);
      complete_run();
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // APB master; an idle cycle follows each transfer so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    tmo(k, 20);
  endtask

  // Polls status until the given bit is set; the read also arms flag clearing
  task automatic wait_stat(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 600);
    tmo(k, 600);
  endtask

  task automatic wait_cnt(input int tgt);
    int k;
    k = 0;
    while (peer.ev_count < tgt && k < 9000) begin
      @(posedge clk);
      k++;
    end
    tmo(k, 9000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(txd, 32'h1);
    check(tx_owned, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd, 32'hc0);
    apb(1'b0, OFF_BAUD, 32'h0);
    check(rd, {16'h0, BAUD_RST});
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, perr}, 32'h1);
    done("reset");
    // Preamble first, then three frames with the buffer refilled while busy
    apb(1'b1, OFF_BAUD, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h3);
    t_en = $time;
    apb(1'b1, OFF_DATA, 32'h55);
    wait_stat(SB_TX_BUFFER_EMPTY);
    apb(1'b1, OFF_DATA, 32'h0f);
    wait_stat(SB_TX_BUFFER_EMPTY);
    apb(1'b1, OFF_DATA, 32'hf0);
    wait_cnt(1);
    check(peer.got_byte, 32'h55);
    check(peer.first_start >= t_en + 10 * BIT_CLKS * 20, 32'h1);
    wait_cnt(2);
    check(peer.got_byte, 32'h0f);
    wait_cnt(3);
    check(peer.got_byte, 32'hf0);
    wait_stat(SB_TC);
    check(rd, 32'hc0);
    done("transmit");
    // Break queued behind a busy shifter, normal then long
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_DATA, 32'hff);
      wait_stat(SB_TX_BUFFER_EMPTY);
      apb(1'b1, OFF_CTRL, k ? 32'hf : 32'h7);
      apb(1'b1, OFF_CTRL, k ? 32'hb : 32'h3);
      wait_cnt(5 + 2 * k);
      check(peer.low_len, k ? 13 * BIT_CLKS : 10 * BIT_CLKS);
    end
    done("break");
    // Receive, clear, overrun, noise, framing
    peer.send(8'ha3, 1'b1, -1);
    wait_stat(SB_RX_BUFFER_FULL);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'ha3);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd & 32'hfe, 32'hc0);
    peer.send(8'h11, 1'b1, -1);
    peer.send(8'h22, 1'b1, -1);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd & 32'hfe, 32'he8);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'h11);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd & 32'hfe, 32'hc0);
    peer.send(8'h0f, 1'b1, 5);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd & 32'hfe, 32'he4);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'h0f);
    peer.send(8'h5a, 1'b0, -1);
    peer.send(8'h33, 1'b1, -1);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rd & 32'hf6, 32'he2);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'h5a);
    done("receive");
    // Disable while a frame is in flight, then inverted idle
    apb(1'b1, OFF_DATA, 32'h81);
    wait_stat(SB_TX_BUFFER_EMPTY);
    apb(1'b1, OFF_CTRL, 32'h0);
    check(tx_owned, 32'h1);
    wait_cnt(8);
    check(peer.got_byte, 32'h81);
    n = 0;
    while (tx_owned !== 1'b0 && n < 64) begin
      @(posedge clk);
      n++;
    end
    check(tx_owned, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h20);
    repeat (2) @(posedge clk);
    check(txd, 32'h0);
    done("release");
    complete_run();
  end
endmodule
